// *** tcc_defs.svh ***
// Constants for the temperature conversion control block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// ==========================================================
// Register byte offsets (APB, word aligned)
`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_STAT 12'h004
`define TCC_OFF_RESULT 12'h008
`define TCC_OFF_THIGH 12'h00C
`define TCC_OFF_TLOW 12'h010
`define TCC_OFF_ADDR 12'h014
`define TCC_OFF_SENSE 12'h018
// ==========================================================
// Control field positions
`define TCC_CTRL_MODE_LO 0
`define TCC_CTRL_MODE_HI 1
`define TCC_CTRL_RATE_LO 2
`define TCC_CTRL_RATE_HI 3
`define TCC_CTRL_EXT 4
`define TCC_CTRL_BREAK 5
// ==========================================================
// Reset values
`define TCC_CTRL_RST 6'h02
`define TCC_ADDR_RST 4'h0
`define TCC_LIMIT_RST 13'h0000
// ==========================================================
// Timing figures
`define TCC_CLK_HZ 25000000
`define TCC_CONV_MS 26
`define TCC_TOUT_MS 28
`define TCC_CONV_CYC (`TCC_CONV_MS * (`TCC_CLK_HZ / 1000))
`define TCC_TOUT_CYC (`TCC_TOUT_MS * (`TCC_CLK_HZ / 1000))
// Saturation ceilings and chain length limit
`define TCC_SAT12 13'h07FF
`define TCC_SAT13 13'h0FFF
`define TCC_CHAIN_MAX 16
`endif

// *** tcc_host_model.sv ***
// Host model that frames bytes into the chain input
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model #(
  parameter int BIT_CYC = 4
)
(
  input wire logic mclk,
  output logic line,
  output logic byte_done,
  output logic [7:0] byte_val
);
  // ========
  // Line rests high between frames, as a UART does
  initial
  begin
    line = 1'b1;
    byte_done = 1'b0;
    byte_val = 8'h00;
  end
  // One framed byte; the bench opens the link traffic with 55h
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      line <= f[i];
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
    @(posedge mclk);
    byte_done <= 1'b1;
    byte_val <= b;
    @(posedge mclk);
    byte_done <= 1'b0;
    // Stale byte is not left standing once the strobe drops
    byte_val <= ~b;
  endtask : send
endmodule : tcc_host_model
`default_nettype wire

// *** tcc_pkg.sv ***
// Types for the temperature conversion control block
package tcc_pkg;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    TCC_IDLE,
    TCC_CONV,
    TCC_WAIT
  } tcc_state_t;
  // Interface framing states
  typedef enum logic [1:0] {
    TCC_LK_CAL,
    TCC_LK_CMD,
    TCC_LK_DATA
  } tcc_link_t;
endpackage : tcc_pkg

// *** tcc_top.sv ***
// Conversion sequencing, result formatting and chain control
//
// Summary of operation
// - Chain holds up to sixteen devices
// - Pass-through copies input to output directly
// - Device may break chain, drive own output
// - Device keeps its own chain address
// - Global commands reach all devices too
// - Conversion starts at reset, result after 26ms
// - Two's-complement result, LSB one sixteenth degree
// - Saturate at 7FFh or FFFh
// - Extended range clear at reset, widens registers
// - Extended bit sampled at conversion end
// - Extra limit bit kept when range cleared
// - 28ms silence resets interface to calibration
// - Each byte restarts inactivity timer
// - Continuous mode waits selected period
// - Mode 00 powers down conversion
// - Shutdown finishes running conversion first
// - One-shot from shutdown reads 01 then returns 00
// - Bytes framed start low, stop high, LSB first
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"

module tcc_top
  import tcc_pkg::*;
#(
  parameter int unsigned CONV_CYC = `TCC_CONV_CYC,
  parameter int unsigned TOUT_CYC = `TCC_TOUT_CYC,
  parameter int unsigned PER0_CYC = 100000000,
  parameter int unsigned PER1_CYC = 25000000,
  parameter int unsigned PER2_CYC = 6250000,
  parameter int unsigned PER3_CYC = 3125000
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chain_in,
  output logic chain_out,
  input wire logic byte_done,
  input wire logic [7:0] byte_val,
  input wire logic [12:0] sense_raw,
  output logic link_reset,
  output logic conv_active
);

  // ========================================================
  // Register state
  logic [5:0] ctrl_r;        // Mode, rate, range, break
  logic [12:0] result_r;     // Formatted result
  logic [12:0] thigh_r;      // High limit incl. extra bit
  logic [12:0] tlow_r;       // Low limit incl. extra bit
  logic [3:0] addr_r;        // Chain position address, 16 slots
  logic ext_act_r;           // Range latched at conversion end
  tcc_state_t state_r;       // Sequencer state
  tcc_link_t link_r;         // Framing state
  logic [31:0] cnt_r;        // Conversion / wait counter
  logic [31:0] tout_r;       // Inactivity counter
  logic [2:0] rx_sync_r;     // Chain input synchroniser
  logic rx_r;                // Filtered chain input

  // ========================================================
  // Decode
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = paddr == `TCC_OFF_CTRL;
  wire hit_stat = paddr == `TCC_OFF_STAT;
  wire hit_res = paddr == `TCC_OFF_RESULT;
  wire hit_hi = paddr == `TCC_OFF_THIGH;
  wire hit_lo = paddr == `TCC_OFF_TLOW;
  wire hit_addr = paddr == `TCC_OFF_ADDR;
  wire hit_sense = paddr == `TCC_OFF_SENSE;
  wire mapped = hit_ctrl | hit_stat | hit_res | hit_hi | hit_lo
                | hit_addr | hit_sense;
  wire [1:0] mode = ctrl_r[`TCC_CTRL_MODE_HI:`TCC_CTRL_MODE_LO];
  wire [1:0] conv_period_sel = ctrl_r[`TCC_CTRL_RATE_HI:`TCC_CTRL_RATE_LO];
  wire extended_range_enable = ctrl_r[`TCC_CTRL_EXT];
  wire chain_break = ctrl_r[`TCC_CTRL_BREAK];
  wire conv_mode_high_bit = mode[1];
  wire conv_end = (state_r == TCC_CONV) && (cnt_r == 32'h0000_0001);
  wire oneshot_wr = wr_en && hit_ctrl && (mode == 2'h0)
                    && (pwdata[1:0] == 2'h1);

  // Saturating format; negatives kept raw in extended range, else bit 12 cleared with floor 800h
  function automatic logic [12:0] fmt(input logic [12:0] raw,
                                      input logic ext);
    logic [12:0] sat;
    sat = ext ? `TCC_SAT13 : `TCC_SAT12;
    if (raw[12])
      fmt = ext ? raw : {1'b0, 12'hFFF & raw[11:0]} | 13'h0000;
    else if (raw > sat)
      fmt = sat;
    else
      fmt = raw;
    if (!ext && raw[12])
      fmt = {1'b0, raw[11] ? raw[11:0] : 12'h800};
  endfunction : fmt

  // Period per rate code
  function automatic logic [31:0] period(input logic [1:0] sel);
    unique case (sel)
      2'h0: period = PER0_CYC;
      2'h1: period = PER1_CYC;
      2'h2: period = PER2_CYC;
      2'h3: period = PER3_CYC;
    endcase
  endfunction : period

  // ========================================================
  // Pass-through without delay unless broken out
  assign chain_out = chain_break ? rx_r : chain_in;
  assign conv_active = state_r == TCC_CONV;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ========================================================
  // APB read mux, registered data
  always_ff @(posedge mclk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= hit_ctrl ? {26'h0, ctrl_r} :
                hit_stat ? {29'h0, ext_act_r, link_r} :
                hit_res ? {19'h0, result_r} :
                hit_hi ? {19'h0, thigh_r} :
                hit_lo ? {19'h0, tlow_r} :
                hit_addr ? {28'h0, addr_r} : 32'h0000_0000;
  end

  // ========================================================
  // Control and limit registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r <= `TCC_CTRL_RST;
      thigh_r <= `TCC_LIMIT_RST;
      tlow_r <= `TCC_LIMIT_RST;
      addr_r <= `TCC_ADDR_RST;
    end
    else
    begin
      if (wr_en && hit_ctrl)
        ctrl_r <= pwdata[5:0];
      else if (conv_end && mode == 2'h1)
        ctrl_r[1:0] <= 2'h0;
      // Extra bit writable only in extended range; kept otherwise
      if (wr_en && hit_hi)
        thigh_r <= {extended_range_enable ? pwdata[12] : thigh_r[12],
                    pwdata[11:0]};
      if (wr_en && hit_lo)
        tlow_r <= {extended_range_enable ? pwdata[12] : tlow_r[12],
                   pwdata[11:0]};
      if (wr_en && hit_addr)
        addr_r <= pwdata[3:0];
    end
  end

  // ========================================================
  // Conversion sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= TCC_CONV;
      cnt_r <= CONV_CYC;
      result_r <= 13'h0000;
      ext_act_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        TCC_IDLE:
          if (oneshot_wr || conv_mode_high_bit)
          begin
            state_r <= TCC_CONV;
            cnt_r <= CONV_CYC;
          end
        TCC_CONV:
          if (conv_end)
          begin
            // Range sampled only here, so a mid-conversion change waits
            ext_act_r <= extended_range_enable;
            result_r <= fmt(sense_raw, extended_range_enable);
            if (conv_mode_high_bit)
            begin
              state_r <= TCC_WAIT;
              cnt_r <= period(conv_period_sel);
            end
            else
              state_r <= TCC_IDLE;
          end
          else
            cnt_r <= cnt_r - 32'h1;
        TCC_WAIT:
          if (!conv_mode_high_bit)
            state_r <= TCC_IDLE;
          else if (cnt_r <= 32'h1)
          begin
            state_r <= TCC_CONV;
            cnt_r <= CONV_CYC;
          end
          else
            cnt_r <= cnt_r - 32'h1;
      endcase
    end
  end

  // ========================================================
  // Chain input synchroniser, 2nd and 3rd must agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_sync_r <= 3'h7;
      rx_r <= 1'b1;
    end
    else
    begin
      rx_sync_r <= {rx_sync_r[1:0], chain_in};
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_r <= rx_sync_r[2];
    end
  end

  // ========================================================
  // Framing and inactivity timeout
  wire tout_hit = (link_r != TCC_LK_CAL) && (tout_r == TOUT_CYC - 1);
  wire is_global = byte_val[7];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      link_r <= TCC_LK_CAL;
      tout_r <= 32'h0;
      link_reset <= 1'b0;
    end
    else
    begin
      link_reset <= tout_hit;
      if (byte_done)
      begin
        tout_r <= 32'h0;
        unique case (link_r)
          TCC_LK_CAL: link_r <= TCC_LK_CMD;
          TCC_LK_CMD:
            link_r <= (is_global || byte_val[6:3] == addr_r)
                      ? TCC_LK_DATA : TCC_LK_CAL;
          TCC_LK_DATA: link_r <= TCC_LK_DATA;
        endcase
      end
      else if (tout_hit)
      begin
        link_r <= TCC_LK_CAL;
        tout_r <= 32'h0;
      end
      else if (link_r != TCC_LK_CAL)
        tout_r <= tout_r + 32'h1;
    end
  end

  // ========================================================
  // Assertions
  property p_pass;
    @(posedge mclk) disable iff (rst)
      !chain_break |-> chain_out == chain_in;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through broken");
  // Broken chain drives the filtered input once 2nd and 3rd agree
  property p_brk;
    @(posedge mclk) disable iff (rst)
      (chain_break && (rx_sync_r[1] == rx_sync_r[2])) ##1 chain_break
        |-> chain_out == $past(rx_sync_r[2]);
  endproperty
  a_brk: assert property (p_brk) else $error("break not driving");
  property p_sat12;
    @(posedge mclk) disable iff (rst)
      !ext_act_r |-> result_r[12] == 1'b0;
  endproperty
  a_sat12: assert property (p_sat12) else $error("sat12 exceeded");
  property p_oneshot;
    @(posedge mclk) disable iff (rst)
      conv_end && mode == 2'h1 && !(wr_en && hit_ctrl)
        |=> mode == 2'h0;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot stuck");
  property p_shut;
    @(posedge mclk) disable iff (rst)
      state_r == TCC_WAIT && !conv_mode_high_bit |=> state_r == TCC_IDLE;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown ignored");
  property p_finish;
    @(posedge mclk) disable iff (rst)
      conv_end |=> state_r != TCC_CONV;
  endproperty
  a_finish: assert property (p_finish) else $error("conv not ended");
  property p_ext;
    @(posedge mclk) disable iff (rst)
      conv_end |=> ext_act_r == $past(extended_range_enable);
  endproperty
  a_ext: assert property (p_ext) else $error("range not sampled");
  property p_tout;
    @(posedge mclk) disable iff (rst)
      tout_hit && !byte_done |=> link_r == TCC_LK_CAL && link_reset;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout missed");
  property p_byte;
    @(posedge mclk) disable iff (rst)
      byte_done |=> tout_r == 32'h0;
  endproperty
  a_byte: assert property (p_byte) else $error("timer not cleared");
  c_conv: cover property (@(posedge mclk) disable iff (rst) conv_end);
  c_tout: cover property (@(posedge mclk) disable iff (rst) tout_hit);
  c_wait: cover property (@(posedge mclk) disable iff (rst)
    state_r == TCC_WAIT);

endmodule : tcc_top
`default_nettype wire

// *** test_temp_conversion_control.sv ***
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module test_temp_conversion_control;
  import tcc_pkg::*;
  // ========
  // Short counts keep the run brief
  localparam int PER [4] = '{20, 40, 60, 80};
  localparam int CONV_N = 50;
  localparam int TOUT_N = 60;
  localparam logic [12:0] CORN [5] = '{13'h07D0, 13'h0960, 13'h1FFF,
    13'h1D80, 13'h1000};
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic chain_in, chain_out, byte_done, link_reset, conv_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] byte_val;
  logic [12:0] sense_raw, r, m;
  logic [3:0] h;
  int n_errors, checks, cyc, lr_n, n, hi;
  tcc_top #(.CONV_CYC(CONV_N), .TOUT_CYC(TOUT_N), .PER0_CYC(PER[0]),
    .PER1_CYC(PER[1]), .PER2_CYC(PER[2]), .PER3_CYC(PER[3]))
    i_tcc_top (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chain_in(chain_in), .chain_out(chain_out), .byte_done(byte_done),
    .byte_val(byte_val), .sense_raw(sense_raw), .link_reset(link_reset),
    .conv_active(conv_active));
  tcc_host_model i_tcc_host_model (.mclk(mclk),
    .line(chain_in), .byte_done(byte_done), .byte_val(byte_val));
  // ========
  // Clock, hang guard and pulse monitor on the quiet edge
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end
  always @(negedge mclk)
    if (link_reset === 1'b1)
      lr_n++;
  // ========
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  // APB transfer held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No local limit; pready high or the bench's hang guard ends this wait
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for a conversion to begin and end, counting its length
  task automatic wait_end();
    n = 0;
    hi = 0;
    while (conv_active !== 1'b1 && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
    while (conv_active === 1'b1 && n < 500)
    begin
      @(negedge mclk);
      n++;
      hi++;
    end
    if (n >= 500)
      chk(32'h0, 32'h1);
  endtask : wait_end
  // Idle cycles until the next conversion starts
  task automatic gap_len();
    n = 0;
    while (conv_active !== 1'b1 && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
  endtask : gap_len
  // Saturating 12-bit view; 13-bit view is the raw reading
  function automatic logic [12:0] fmt(input logic [12:0] v, input logic x);
    if (!x && !v[12] && v[11])
      return 13'h07FF;
    if (!x && v[12] && !v[11])
      return 13'h1800;
    return v;
  endfunction : fmt
  // Counts drift a cycle or two with edge placement
  function automatic logic [31:0] near(input int a, input int b);
    return 32'(a >= b - 2 && a <= b + 2);
  endfunction : near
  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // ========
  // Main sequence
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, sense_raw} = '0;
    void'($urandom(71529));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(32'(conv_active), 32'h1);
    apb(1'b0, `TCC_OFF_CTRL, 32'h0);
    chk(q, 32'h02);
    // Result formatting in both ranges, corners then random
    for (int x = 0; x < 2; x++)
    begin
      apb(1'b1, `TCC_OFF_CTRL, {27'h0, x[0], 4'h2});
      wait_end();
      apb(1'b0, `TCC_OFF_STAT, 32'h0);
      chk(32'(q[2]), 32'(x[0]));
      for (int k = 0; k < 9; k++)
      begin
        r = (k < 5) ? CORN[k] : 13'($urandom);
        @(posedge mclk);
        sense_raw <= r;
        wait_end();
        apb(1'b0, `TCC_OFF_RESULT, 32'h0);
        m = x[0] ? 13'h1FFF : 13'h0FFF;
        chk(32'(q[12:0] & m), 32'(fmt(r, x[0]) & m));
      end
    end
    // Continuous mode idle gap for each rate code
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, `TCC_OFF_CTRL, {28'h0, 2'(p), 2'h2});
      wait_end();
      gap_len();
      chk(near(n, PER[p]), 32'h1);
      wait_end();
      chk(near(hi, CONV_N), 32'h1);
    end
    // Shutdown requested mid-conversion finishes it first
    gap_len();
    apb(1'b1, `TCC_OFF_CTRL, 32'h0);
    @(posedge mclk);
    sense_raw <= 13'h0123;
    @(negedge mclk);
    chk(32'(conv_active), 32'h1);
    wait_end();
    apb(1'b0, `TCC_OFF_RESULT, 32'h0);
    chk(32'(q[11:0]), 32'h123);
    n = 0;
    repeat (100)
    begin
      @(negedge mclk);
      n += int'(conv_active !== 1'b0);
    end
    chk(32'(n), 32'h0);
    // One conversion from shutdown, mode field reads back
    apb(1'b1, `TCC_OFF_CTRL, 32'h01);
    apb(1'b0, `TCC_OFF_CTRL, 32'h0);
    chk(32'(q[1:0]), 32'h1);
    wait_end();
    apb(1'b0, `TCC_OFF_CTRL, 32'h0);
    chk(32'(q[1:0]), 32'h0);
    // Extra limit bit follows the live range setting
    apb(1'b1, `TCC_OFF_CTRL, 32'h10);
    apb(1'b1, `TCC_OFF_THIGH, 32'h1ABC);
    apb(1'b0, `TCC_OFF_THIGH, 32'h0);
    chk(q, 32'h1ABC);
    apb(1'b1, `TCC_OFF_CTRL, 32'h00);
    apb(1'b1, `TCC_OFF_THIGH, 32'h0123);
    apb(1'b0, `TCC_OFF_THIGH, 32'h0);
    chk(q, 32'h1123);
    apb(1'b1, `TCC_OFF_TLOW, 32'h1456);
    apb(1'b0, `TCC_OFF_TLOW, 32'h0);
    chk(q, 32'h0456);
    apb(1'b1, `TCC_OFF_ADDR, 32'h5);
    apb(1'b0, `TCC_OFF_ADDR, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, `TCC_OFF_SENSE, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // Link traffic with pass-through watched alongside
    fork
      begin
        i_tcc_host_model.send(8'h55);
        apb(1'b0, `TCC_OFF_STAT, 32'h0);
        chk(32'(q[1:0]), 32'(TCC_LK_CMD));
        repeat (12) @(posedge mclk);
        i_tcc_host_model.send(8'($urandom));
        repeat (12) @(posedge mclk);
        i_tcc_host_model.send(8'($urandom));
        chk(32'(lr_n), 32'h0);
        n = 0;
        while (link_reset !== 1'b1 && n < 200)
        begin
          @(negedge mclk);
          n++;
        end
        chk(near(n, TOUT_N), 32'h1);
        apb(1'b0, `TCC_OFF_STAT, 32'h0);
        chk(32'(q[1:0]), 32'(TCC_LK_CAL));
        chk(32'(lr_n), 32'h1);
      end
      repeat (200)
      begin
        @(negedge mclk);
        chk(32'(chain_out), 32'(chain_in));
      end
    join
    // Broken chain: own output follows the filtered input, four late
    apb(1'b1, `TCC_OFF_CTRL, 32'h20);
    h = 4'hF;
    fork
      i_tcc_host_model.send(8'($urandom));
      repeat (44)
      begin
        @(negedge mclk);
        chk(32'(chain_out), 32'(h[3]));
        h = {h[2:0], chain_in};
      end
    join
    finish_test();
  end
endmodule : test_temp_conversion_control
`default_nettype wire
